// ---- rtl/logic_cell_pkg.sv ----
// constants shared by the configurable logic cell datapath and register port
// assumes one clock domain; routing inputs come from logic on that clock
package logic_cell_pkg;
    // working register offsets on the cell register port
    localparam logic [2:0] OFS_ACC_ZERO   = 3'h0;
    localparam logic [2:0] OFS_ACC_ONE    = 3'h1;
    localparam logic [2:0] OFS_OPND_ZERO  = 3'h2;
    localparam logic [2:0] OFS_OPND_ONE   = 3'h3;
    localparam logic [2:0] OFS_QUEUE_ZERO = 3'h4;
    localparam logic [2:0] OFS_QUEUE_ONE  = 3'h5;
    // reset values
    localparam logic [7:0]  RST_WORK  = 8'h00;
    localparam logic [15:0] RST_CWORD = 16'h0000;
    // configuration word field positions
    localparam int CW_FUNC_LO  = 0;   // [2:0] arithmetic function
    localparam int CW_SRCA     = 3;   // 0 acc zero, 1 acc one
    localparam int CW_SRCB_LO  = 4;   // [5:4] opnd0, opnd1, acc0, acc1
    localparam int CW_A0WR_LO  = 6;   // [7:6] none, result, queue zero
    localparam int CW_A1WR_LO  = 8;   // [9:8] none, result, queue one
    localparam int CW_D0LD     = 10;  // opnd zero loads from queue zero
    localparam int CW_D1LD     = 11;  // opnd one loads from queue one
    localparam int CW_Q0PUSH   = 12;  // datapath pushes into queue zero
    localparam int CW_Q1PUSH   = 13;  // datapath pushes into queue one
    localparam int CW_PUSHSRC  = 14;  // 0 result, 1 operand a
    localparam int CW_CARRY    = 15;  // carry in for add and subtract
    // accumulator write selections
    localparam logic [1:0] ACCW_NONE  = 2'h0;
    localparam logic [1:0] ACCW_ALU   = 2'h1;
    localparam logic [1:0] ACCW_QUEUE = 2'h2;
    // arithmetic functions
    typedef enum logic [2:0] {
        FN_INC  = 3'b000,
        FN_DEC  = 3'b001,
        FN_ADD  = 3'b010,
        FN_SUB  = 3'b011,
        FN_AND  = 3'b100,
        FN_OR   = 3'b101,
        FN_XOR  = 3'b110,
        FN_PASS = 3'b111
    } alu_fn_t;
endpackage

// ---- rtl/configurable_logic_cell.sv ----
// configurable logic cell: two twelve-input arrays, 8-bit datapath, queues
// assumes routing inputs and register port run on core_clk_in
// What this block does
// RL1 - two independent twelve-input arrays with constant OR width per cell
// RL2 - each array takes twelve routed inputs shared over eight product terms
// RL3 - product term ANDs one to twelve inputs, true or complement each
// RL4 - each output ORs one to eight terms; OR width eight everywhere
// RL5 - each array output selectable as registered or combinational
// RL6 - datapath does one 8-bit operation per cycle with compare conditions
// RL7 - six working registers reachable by bus while the cell runs
// RL8 - accumulators are operand sources, result sinks and compare sources
// RL9 - operand registers are operand and compare sources, never result sinks
// RL10 - two four-byte queues load or capture registers and results
// RL11 - queues are the main parallel path between bus and cell
// RL12 - eight sixteen-bit configuration words, each a whole datapath setup
// RL13 - routed address picks the configuration word used this cycle
// RL14 - per sub-block enables and local reset gate cell operation
// RL15 - increment, decrement, add, subtract, and, or, xor, pass
// RL16 - each queue is an input or an output buffer, chosen independently
// RL17 - each array drives four outputs from its eight shared terms
// RL18 - bus never writes a full input queue nor reads an empty one
`timescale 1ns/100ps
module configurable_logic_cell #(
    parameter int QDEPTH = 4
) (
    input  wire logic                    core_clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic                    clk_en_in,
    input  wire logic [1:0]              pla_en_in,
    input  wire logic                    dp_en_in,
    input  wire logic                    dp_srst_in,
    input  wire logic [1:0][11:0]        pla_data_in,
    input  wire logic [1:0][7:0][11:0]   pla_true_sel_in,
    input  wire logic [1:0][7:0][11:0]   pla_comp_sel_in,
    input  wire logic [1:0][3:0][7:0]    pla_or_sel_in,
    input  wire logic [1:0][3:0]         pla_reg_sel_in,
    output logic      [1:0][3:0]         pla_out,
    input  wire logic [2:0]              cfg_addr_in,
    input  wire logic                    cram_wr_in,
    input  wire logic [2:0]              cram_waddr_in,
    input  wire logic [15:0]             cram_wdata_in,
    input  wire logic [1:0]              queue_out_mode_in,
    input  wire logic [2:0]              bus_addr_in,
    input  wire logic                    bus_wr_in,
    input  wire logic                    bus_rd_in,
    input  wire logic [7:0]              bus_wdata_in,
    output logic      [7:0]              bus_rdata_out,
    output logic                         bus_ack_out,
    output logic      [5:0]              cond_out,
    output logic      [1:0][2:0]         queue_cnt_out,
    output logic      [7:0]              res_data_out,
    output logic                         res_valid_out,
    input  wire logic                    res_ready_in
);
    typedef struct packed {
        logic [7:0]                 acc0;
        logic [7:0]                 acc1;
        logic [7:0]                 opnd0;
        logic [7:0]                 opnd1;
        logic [1:0][QDEPTH-1:0][7:0] qmem;
        logic [1:0][1:0]            rptr;
        logic [1:0][1:0]            wptr;
        logic [1:0][2:0]            qcnt;
        logic [7:0][15:0]           cram;
        logic [1:0][3:0]            pla_q;
        logic [7:0]                 rdata;
        logic                       ack;
        logic [5:0]                 cond;
        logic [1:0][7:0]            skid;
        logic [1:0]                 skid_v;
    } cell_state_t;

    cell_state_t state_ff;
    cell_state_t nxt_state;

    logic [1:0][7:0] pterm;
    logic [1:0][3:0] pla_sum;

    // product terms and sums of both arrays
    genvar gb, gt;
    generate
        for (gb = 0; gb < 2; gb++) begin : g_pla
            for (gt = 0; gt < 8; gt++) begin : g_term
                assign pterm[gb][gt] =
                    (|(pla_true_sel_in[gb][gt] | pla_comp_sel_in[gb][gt])) &
                    (&((pla_data_in[gb] | ~pla_true_sel_in[gb][gt]) &
                       (~pla_data_in[gb] | ~pla_comp_sel_in[gb][gt]))); // [RL2] [RL3]
            end
            for (gt = 0; gt < 4; gt++) begin : g_sum
                assign pla_sum[gb][gt] = |(pterm[gb] & pla_or_sel_in[gb][gt]); // [RL4] [RL17]
                // registered or combinational output per bit
                assign pla_out[gb][gt] = pla_reg_sel_in[gb][gt] ?
                                         state_ff.pla_q[gb][gt] : pla_sum[gb][gt]; // [RL5] [RL1]
            end
        end
    endgenerate

    localparam int CW_SRCA_IDX = logic_cell_pkg::CW_SRCA;

    logic [15:0] cw;
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic [8:0]  alu;
    logic [1:0]  a_wr;
    logic [1:0]  pop_dp;
    logic [1:0]  push_dp;
    logic [1:0]  q_empty;
    logic [1:0]  q_full;
    logic        emit;
    logic        stall;
    logic        exec;
    logic [7:0]  push_val;
    logic [1:0]  q_push;
    logic [1:0]  q_pop;
    logic [1:0][7:0] q_pdat;
    logic [1:0][7:0] q_head;

    // datapath cycle, queues, register port and result buffer
    always_comb begin
        nxt_state = state_ff;
        cw = state_ff.cram[cfg_addr_in]; // [RL13]
        opa = cw[CW_SRCA_IDX] ? state_ff.acc1 : state_ff.acc0; // [RL8]
        unique case (cw[logic_cell_pkg::CW_SRCB_LO +: 2])
            2'h0:    opb = state_ff.opnd0; // [RL9]
            2'h1:    opb = state_ff.opnd1;
            2'h2:    opb = state_ff.acc0;
            default: opb = state_ff.acc1;
        endcase
        unique case (logic_cell_pkg::alu_fn_t'(cw[logic_cell_pkg::CW_FUNC_LO +: 3]))
            logic_cell_pkg::FN_INC:  alu = {1'b0, opa} + 9'h001; // [RL15]
            logic_cell_pkg::FN_DEC:  alu = {1'b0, opa} - 9'h001;
            logic_cell_pkg::FN_ADD:  alu = {1'b0, opa} + {1'b0, opb} +
                                           {8'h00, cw[logic_cell_pkg::CW_CARRY]};
            logic_cell_pkg::FN_SUB:  alu = {1'b0, opa} - {1'b0, opb} -
                                           {8'h00, cw[logic_cell_pkg::CW_CARRY]};
            logic_cell_pkg::FN_AND:  alu = {1'b0, opa & opb};
            logic_cell_pkg::FN_OR:   alu = {1'b0, opa | opb};
            logic_cell_pkg::FN_XOR:  alu = {1'b0, opa ^ opb};
            default:                 alu = {1'b0, opa};
        endcase
        a_wr = {cw[logic_cell_pkg::CW_A1WR_LO +: 2] == logic_cell_pkg::ACCW_QUEUE,
                cw[logic_cell_pkg::CW_A0WR_LO +: 2] == logic_cell_pkg::ACCW_QUEUE};
        pop_dp  = {(a_wr[1] | cw[logic_cell_pkg::CW_D1LD]) & ~queue_out_mode_in[1],
                   (a_wr[0] | cw[logic_cell_pkg::CW_D0LD]) & ~queue_out_mode_in[0]};
        push_dp = {cw[logic_cell_pkg::CW_Q1PUSH] & queue_out_mode_in[1],
                   cw[logic_cell_pkg::CW_Q0PUSH] & queue_out_mode_in[0]}; // [RL16]
        push_val = cw[logic_cell_pkg::CW_PUSHSRC] ? opa : alu[7:0]; // [RL10]
        emit = (cw[logic_cell_pkg::CW_A0WR_LO +: 2] == logic_cell_pkg::ACCW_ALU) |
               (cw[logic_cell_pkg::CW_A1WR_LO +: 2] == logic_cell_pkg::ACCW_ALU);
        for (int i = 0; i < 2; i++) begin
            q_empty[i] = state_ff.qcnt[i] == 3'h0;
            q_full[i]  = state_ff.qcnt[i] == 3'(QDEPTH);
            q_head[i]  = state_ff.qmem[i][state_ff.rptr[i]];
        end
        // a cycle waits rather than read an empty or write a full queue
        stall = |(pop_dp & q_empty) | |(push_dp & q_full) | (emit & state_ff.skid_v[1]);
        exec  = dp_en_in & ~stall & ~dp_srst_in; // [RL14]
        // bus side of the queues: input queues take writes, output queues give reads
        for (int i = 0; i < 2; i++) begin
            q_push[i] = exec & push_dp[i];
            q_pdat[i] = push_val;
            q_pop[i]  = exec & pop_dp[i];
            if (bus_addr_in == logic_cell_pkg::OFS_QUEUE_ZERO + 3'(i)) begin
                if (bus_wr_in & ~queue_out_mode_in[i] & ~q_full[i]) begin
                    q_push[i] = 1'b1; // [RL11] [RL18]
                    q_pdat[i] = bus_wdata_in;
                end
                if (bus_rd_in & queue_out_mode_in[i] & ~q_empty[i]) begin
                    q_pop[i] = 1'b1;
                end
            end
        end
        // arithmetic results and register loads
        if (exec) begin
            if (cw[logic_cell_pkg::CW_A0WR_LO +: 2] == logic_cell_pkg::ACCW_ALU) begin
                nxt_state.acc0 = alu[7:0]; // [RL6] [RL8]
            end else if (a_wr[0] & ~queue_out_mode_in[0]) begin
                nxt_state.acc0 = q_head[0]; // [RL10]
            end
            if (cw[logic_cell_pkg::CW_A1WR_LO +: 2] == logic_cell_pkg::ACCW_ALU) begin
                nxt_state.acc1 = alu[7:0];
            end else if (a_wr[1] & ~queue_out_mode_in[1]) begin
                nxt_state.acc1 = q_head[1];
            end
            if (cw[logic_cell_pkg::CW_D0LD] & ~queue_out_mode_in[0]) begin
                nxt_state.opnd0 = q_head[0];
            end
            if (cw[logic_cell_pkg::CW_D1LD] & ~queue_out_mode_in[1]) begin
                nxt_state.opnd1 = q_head[1];
            end
            nxt_state.cond = {alu[8], &alu[7:0], alu[7:0] == 8'h00,
                              opa < opb, opa == opb, 1'b1}; // [RL6]
        end
        // queue pointers and counts
        for (int i = 0; i < 2; i++) begin
            if (q_push[i]) begin
                nxt_state.qmem[i][state_ff.wptr[i]] = q_pdat[i];
                nxt_state.wptr[i] = state_ff.wptr[i] + 2'h1;
            end
            if (q_pop[i]) begin
                nxt_state.rptr[i] = state_ff.rptr[i] + 2'h1;
            end
            nxt_state.qcnt[i] = state_ff.qcnt[i] + 3'(q_push[i]) - 3'(q_pop[i]);
        end
        // register port: writes land now, read data one cycle later; bus write wins
        nxt_state.ack = bus_rd_in | bus_wr_in;
        nxt_state.rdata = 8'h00;
        unique case (bus_addr_in)
            logic_cell_pkg::OFS_ACC_ZERO: begin
                nxt_state.rdata = state_ff.acc0; // [RL7]
                if (bus_wr_in) nxt_state.acc0 = bus_wdata_in;
            end
            logic_cell_pkg::OFS_ACC_ONE: begin
                nxt_state.rdata = state_ff.acc1;
                if (bus_wr_in) nxt_state.acc1 = bus_wdata_in;
            end
            logic_cell_pkg::OFS_OPND_ZERO: begin
                nxt_state.rdata = state_ff.opnd0;
                if (bus_wr_in) nxt_state.opnd0 = bus_wdata_in;
            end
            logic_cell_pkg::OFS_OPND_ONE: begin
                nxt_state.rdata = state_ff.opnd1;
                if (bus_wr_in) nxt_state.opnd1 = bus_wdata_in;
            end
            logic_cell_pkg::OFS_QUEUE_ZERO: nxt_state.rdata = q_head[0];
            logic_cell_pkg::OFS_QUEUE_ONE:  nxt_state.rdata = q_head[1];
            default:                        nxt_state.rdata = 8'h00;
        endcase
        // two-entry result buffer toward routing
        if (res_ready_in & state_ff.skid_v[0]) begin
            nxt_state.skid[0]   = state_ff.skid[1];
            nxt_state.skid_v[0] = state_ff.skid_v[1];
            nxt_state.skid_v[1] = 1'b0;
        end
        if (exec & emit) begin
            if (!nxt_state.skid_v[0]) begin
                nxt_state.skid[0]   = alu[7:0];
                nxt_state.skid_v[0] = 1'b1;
            end else begin
                nxt_state.skid[1]   = alu[7:0];
                nxt_state.skid_v[1] = 1'b1;
            end
        end
        // configuration words and array state bits
        if (cram_wr_in) nxt_state.cram[cram_waddr_in] = cram_wdata_in; // [RL12]
        for (int i = 0; i < 2; i++) begin
            if (pla_en_in[i]) nxt_state.pla_q[i] = pla_sum[i]; // [RL5] [RL14]
        end
        // local reset of the datapath registers and queues
        if (dp_srst_in) begin
            nxt_state.acc0   = logic_cell_pkg::RST_WORK;
            nxt_state.acc1   = logic_cell_pkg::RST_WORK;
            nxt_state.opnd0  = logic_cell_pkg::RST_WORK;
            nxt_state.opnd1  = logic_cell_pkg::RST_WORK;
            nxt_state.rptr   = '0;
            nxt_state.wptr   = '0;
            nxt_state.qcnt   = '0;
            nxt_state.skid_v = '0;
            nxt_state.cond   = '0;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= '0;
        end else if (clk_en_in) begin
            state_ff <= nxt_state;
        end
    end

    assign bus_rdata_out = state_ff.rdata;
    assign bus_ack_out   = state_ff.ack;
    assign cond_out      = state_ff.cond;
    assign queue_cnt_out = state_ff.qcnt;
    assign res_data_out  = state_ff.skid[0];
    assign res_valid_out = state_ff.skid_v[0];

    default clocking dc @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_queue_bound: assert property (queue_cnt_out[0] <= 3'(QDEPTH)
        && queue_cnt_out[1] <= 3'(QDEPTH)) // [RL10]
        else $error("queue count above depth");
    a_inc_result: assert property (clk_en_in && exec && !bus_wr_in && cw[7:0] == 8'h40
        |=> cond_out[0] && state_ff.acc0 == $past(opa) + 8'h01) // [RL15]
        else $error("increment result wrong");
    a_cram_write: assert property (clk_en_in && cram_wr_in
        |=> state_ff.cram[$past(cram_waddr_in)] == $past(cram_wdata_in)) // [RL12]
        else $error("configuration word not stored");
    a_bus_read: assert property (clk_en_in && bus_rd_in && bus_addr_in == 3'h2 && !dp_srst_in
        |=> bus_ack_out && bus_rdata_out == $past(state_ff.opnd0)) // [RL7]
        else $error("operand register read wrong");
    a_opnd_sink: assert property (clk_en_in && !bus_wr_in && !dp_srst_in
        && !cw[10] && !cw[11] |=> $stable(state_ff.opnd0) && $stable(state_ff.opnd1)) // [RL9]
        else $error("operand register written by datapath");
    a_queue_push: assert property (clk_en_in && bus_wr_in && bus_addr_in == 3'h4
        && !queue_out_mode_in[0] && !q_full[0] && !pop_dp[0] && !dp_srst_in
        |=> queue_cnt_out[0] == $past(queue_cnt_out[0]) + 3'h1) // [RL11]
        else $error("bus write did not fill input queue");
    a_freeze_en: assert property (!clk_en_in |=> $stable(state_ff)) // [RL14]
        else $error("state moved while clock enable low");
    a_pla_reg: assert property (clk_en_in && pla_en_in[0]
        |=> state_ff.pla_q[0] == $past(pla_sum[0])) // [RL5]
        else $error("array register missed sum");
    a_skid_hold: assert property (res_valid_out && !res_ready_in && clk_en_in && !dp_srst_in
        |=> res_valid_out && $stable(res_data_out)) // [RL6]
        else $error("result dropped under stall");
    c_full_queue: cover property (queue_cnt_out[1] == 3'(QDEPTH));
    c_stall: cover property (dp_en_in && stall ##1 !stall);
    c_result: cover property (res_valid_out && res_ready_in);
endmodule // configurable_logic_cell

// ---- verification/cell_bus_master.sv ----
// bus master and result receiver standing beside the logic cell
// assumes the cell takes a request at the rising edge after it is driven
`timescale 1ns/100ps
module cell_bus_master (
    input  wire logic            core_clk_in,
    input  wire logic            bus_ack_in,
    input  wire logic [7:0]      bus_rdata_in,
    input  wire logic [1:0][2:0] queue_cnt_in,
    input  wire logic            hold_in,
    output logic      [2:0]      bus_addr_out,
    output logic                 bus_wr_out,
    output logic                 bus_rd_out,
    output logic      [7:0]      bus_wdata_out,
    output logic                 res_ready_out
);
    // receiver takes results unless told to stall
    assign res_ready_out = !hold_in;
    // idle bus at time zero
    initial begin
        bus_addr_out  = 3'h0;
        bus_wr_out    = 1'b0;
        bus_rd_out    = 1'b0;
        bus_wdata_out = 8'hA5;
    end
    // one register cycle, answer looked at on the falling edge after the taking edge
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic k);
        @(negedge core_clk_in);
        q = 8'h00;
        k = 1'b0;
        if (wr && a[2] && queue_cnt_in[a[0]] == 3'h4) begin
            return;
        end
        bus_addr_out  <= a;
        bus_wr_out    <= wr;
        bus_rd_out    <= !wr;
        bus_wdata_out <= d;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        q = bus_rdata_in;
        k = bus_ack_in;
        bus_wr_out    <= 1'b0;
        bus_rd_out    <= 1'b0;
        bus_wdata_out <= ~d; // data no longer valid
    endtask
endmodule // cell_bus_master

// ---- verification/configurable_logic_cell_datapath_tb.sv ----
// self-checking bench for the configurable logic cell
// assumes the cell package and the bus master model are compiled first
`timescale 1ns/100ps
module configurable_logic_cell_datapath_tb;
    logic                  clk = 1'b0, rst_b = 1'b0, dp_en = 1'b0, cram_wr = 1'b0, hold = 1'b1;
    logic [2:0]            cfg_addr = 3'h0, cram_waddr = 3'h0, addr;
    logic [15:0]           cram_wdata = 16'h0000;
    logic                  clk_en = 1'b1, srst = 1'b0;
    logic [1:0]            qmode = 2'h2, pla_en = 2'h3;
    logic [1:0][11:0]      pdata = '0;
    logic [1:0][7:0][11:0] ts = '0, cs = '0;
    logic [1:0][3:0][7:0]  os = '0;
    logic [1:0][3:0]       rs = '0, pout;
    logic [7:0]            rdata, wdata, rres;
    logic                  ack, wr, rd, rvalid, ready;
    logic [5:0]            cond;
    logic [1:0][2:0]       qcnt;
    int                    n_fail = 0, comparisons = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    configurable_logic_cell uut (.core_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(clk_en),
        .pla_en_in(pla_en), .dp_en_in(dp_en), .dp_srst_in(srst), .pla_data_in(pdata),
        .pla_true_sel_in(ts), .pla_comp_sel_in(cs), .pla_or_sel_in(os), .pla_reg_sel_in(rs),
        .pla_out(pout), .cfg_addr_in(cfg_addr), .cram_wr_in(cram_wr),
        .cram_waddr_in(cram_waddr), .cram_wdata_in(cram_wdata), .queue_out_mode_in(qmode),
        .bus_addr_in(addr), .bus_wr_in(wr), .bus_rd_in(rd), .bus_wdata_in(wdata),
        .bus_rdata_out(rdata), .bus_ack_out(ack), .cond_out(cond), .queue_cnt_out(qcnt),
        .res_data_out(rres), .res_valid_out(rvalid), .res_ready_in(ready));
    cell_bus_master m (.core_clk_in(clk), .bus_ack_in(ack), .bus_rdata_in(rdata),
        .queue_cnt_in(qcnt), .hold_in(hold), .bus_addr_out(addr), .bus_wr_out(wr),
        .bus_rd_out(rd), .bus_wdata_out(wdata), .res_ready_out(ready));
    // compare one byte
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h want %h", $time, s, g, e);
        end
    endtask
    task automatic wrt(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       k;
        m.access(1'b1, a, d, q, k);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic       k;
        m.access(1'b0, a, 8'h00, q, k);
        chk({7'h0, k}, 8'h01, "ack");
        chk(q, e, "read data");
    endtask
    task automatic cram(input logic [2:0] a, input logic [15:0] w);
        @(negedge clk);
        cram_waddr = a;
        cram_wdata = w;
        cram_wr = 1'b1;
        @(negedge clk);
        cram_wr = 1'b0;
    endtask
    // run configuration word a for n edges
    task automatic run(input logic [2:0] a, input int n);
        @(negedge clk);
        cfg_addr = a;
        dp_en = 1'b1;
        repeat (n) @(posedge clk);
        @(negedge clk);
        dp_en = 1'b0;
    endtask
    function automatic logic [7:0] ref_alu(input logic [2:0] f, input logic [7:0] a, b);
        case (f)
            3'h0: return a + 8'h01;
            3'h1: return a - 8'h01;
            3'h2: return a + b;
            3'h3: return a - b;
            3'h4: return a & b;
            3'h5: return a | b;
            3'h6: return a ^ b;
            default: return a;
        endcase
    endfunction
    task automatic t_reset();
        for (int i = 0; i < 7; i++) rdc(i[2:0], 8'h00);
        wrt(3'h7, 8'hFF);
        rdc(3'h7, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_alu();
        wrt(3'h0, 8'h5A);
        wrt(3'h2, 8'h33);
        rdc(3'h2, 8'h33);
        for (int f = 0; f < 8; f++) begin
            cram(f[2:0], 16'h0100 | 16'(f));
            run(f[2:0], 1);
            chk({7'h0, rvalid}, 8'h01, "result valid");
            chk(rres, ref_alu(f[2:0], 8'h5A, 8'h33), "result");
            chk({2'h0, cond}, 8'h01, "conditions");
            hold = 1'b0;
            @(negedge clk);
            hold = 1'b1;
            rdc(3'h1, ref_alu(f[2:0], 8'h5A, 8'h33));
        end
        $display("test alu done");
    endtask
    task automatic t_stall();
        cram(3'h0, 16'h0040);
        run(3'h0, 3);
        chk(rres, 8'h5B, "first held");
        hold = 1'b0;
        @(negedge clk);
        chk(rres, 8'h5C, "second held");
        @(negedge clk);
        chk({7'h0, rvalid}, 8'h00, "drained");
        hold = 1'b1;
        rdc(3'h0, 8'h5C);
        $display("test stall done");
    endtask
    task automatic t_queues();
        for (int i = 1; i < 6; i++) wrt(3'h4, 8'(i * 17));
        chk({5'h0, qcnt[0]}, 8'h04, "queue zero full");
        cram(3'h1, 16'h0400);
        run(3'h1, 5);
        chk({5'h0, qcnt[0]}, 8'h00, "queue zero empty");
        rdc(3'h2, 8'h44);
        cram(3'h2, 16'h600F);
        run(3'h2, 1);
        chk({5'h0, qcnt[1]}, 8'h01, "queue one pushed");
        rdc(3'h5, 8'h5A);
        chk({5'h0, qcnt[1]}, 8'h00, "queue one read");
        $display("test queues done");
    endtask
    task automatic t_pla();
        @(negedge clk);
        for (int k = 0; k < 2; k++) begin
            ts[k][0] = 12'h001;
            cs[k][0] = 12'h002;
            os[k][0] = 8'h01;
            os[k][1] = 8'h01;
            rs[k] = 4'h2;
            pdata[k] = 12'h001;
        end
        #1;
        for (int k = 0; k < 2; k++) chk({6'h0, pout[k][1:0]}, 8'h01, "comb");
        @(negedge clk);
        for (int k = 0; k < 2; k++) chk({6'h0, pout[k][1:0]}, 8'h03, "reg");
        pdata = {2{12'h003}};
        #1;
        for (int k = 0; k < 2; k++) chk({6'h0, pout[k][1:0]}, 8'h02, "comp");
        // with the array enables low the registered bit keeps its old sum
        pla_en = 2'h0;
        @(negedge clk);
        for (int k = 0; k < 2; k++) chk({6'h0, pout[k][1:0]}, 8'h02, "held");
        pla_en = 2'h3;
        $display("test pla done");
    endtask
    // clock enable freezes the cell, local reset clears registers and queues
    task automatic t_ctrl();
        logic [7:0] q;
        logic       k;
        wrt(3'h0, 8'h3C);
        @(negedge clk);
        clk_en = 1'b0;
        m.access(1'b1, 3'h0, 8'h77, q, k);
        chk({7'h0, k}, 8'h00, "frozen ack");
        clk_en = 1'b1;
        rdc(3'h0, 8'h3C);
        wrt(3'h4, 8'h11);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        rdc(3'h0, 8'h00);
        chk({5'h0, qcnt[0]}, 8'h00, "queue cleared");
        $display("test control done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_alu();
        t_stall();
        t_queues();
        t_pla();
        t_ctrl();
        final_report();
    end
    // watchdog
    initial begin
        #(50 * 4000);
        n_fail++;
        final_report();
    end
endmodule // configurable_logic_cell_datapath_tb
